// ==== rtl/srs_defs.vh ====
// constants for the speed reference shaper: map, fields, resets, ranges, timing
`ifndef SRS_DEFS_VH
`define SRS_DEFS_VH

// ****************************************
// timing
// ****************************************
`define SRS_CLK_NS        10
`define SRS_MS_NS         1000000
`define SRS_AO_SAMPLES    16
`define SRS_AO_SHIFT      4

// ****************************************
// register byte offsets
// ****************************************
`define SRS_A_CTRL        8'h00
`define SRS_A_MODE        8'h04
`define SRS_A_GAIN        8'h08
`define SRS_A_ACCEL       8'h0c
`define SRS_A_DECEL       8'h10
`define SRS_A_SRISE       8'h14
`define SRS_A_FILT        8'h18
`define SRS_A_THR         8'h1c
`define SRS_A_ALLOC_A     8'h20
`define SRS_A_ALLOC_B     8'h24
`define SRS_A_OFFSET      8'h28
`define SRS_A_STATUS      8'h2c
`define SRS_A_SPEED       8'h30

// ****************************************
// fields
// ****************************************
`define SRS_CTRL_RESTART  0
`define SRS_CTRL_FACTORY  1
`define SRS_CTRL_AUTO_OFS 2
`define SRS_MODE_CTL_LSB  0
`define SRS_MODE_CRV_LSB  4
`define SRS_MODE_SHP_LSB  6
`define SRS_CTL_ANALOG    4'h0
`define SRS_CTL_ZERO_CLAMP_INPUT    4'ha
`define SRS_CRV_RAMP      2'h0
`define SRS_CRV_SCURVE    2'h1
`define SRS_CRV_FILT1     2'h2
`define SRS_CRV_FILT2     2'h3

// ****************************************
// reset values and ranges
// ****************************************
`define SRS_RST_MODE      8'h00
`define SRS_RST_GAIN      12'h096
`define SRS_RST_TIME      14'h0000
`define SRS_RST_THR       12'h00a
`define SRS_RST_ALLOC     8'hff
`define SRS_MAX_GAIN      32'h00000bb8
`define SRS_MAX_TIME      32'h00002710
`define SRS_MAX_THR       32'h00000bb8
`define SRS_OFS_LIMIT     12'sh400
`define SRS_PIN_NONE_MIN  4'h8
`define SRS_HOLD_KP       8'h04
`define SRS_SCURVE_FULL   11'h400
`define SRS_DIV1000_MUL   25'sh0004189
`define SRS_DIV1000_SH    24

`endif

// ==== rtl/srs_lpf.v ====
// first-order low-pass stage with a millisecond time constant
`timescale 1ns/1ps
module srs_lpf #(
    parameter CYC_PER_MS = 100000
) (
    input  wire               clk,
    input  wire               reset,
    input  wire [13:0]        tau_ms,
    input  wire signed [15:0] din,
    output wire signed [15:0] dout
);
    reg  signed [25:0] y_q;
    reg         [31:0] cnt_q;
    wire        [39:0] prod  = tau_ms * CYC_PER_MS;
    wire        [31:0] intvl = (prod[41-2:10] == 30'h0) ? 32'h1 : {2'h0, prod[39:10]};
    wire signed [25:0] x_fp  = {din, 10'h000};
    wire signed [25:0] diff  = x_fp - y_q;

    assign dout = y_q[25:10];

    // one update per tau/1024 ms, step of 1/1024 of the error: time constant near tau
    always @(posedge clk) begin
        if (reset) begin
            y_q   <= 26'sh0;
            cnt_q <= 32'h0;
        end else if (tau_ms == 14'h0) begin
            y_q   <= x_fp;
            cnt_q <= 32'h0;
        end else if (cnt_q >= intvl - 32'h1) begin
            cnt_q <= 32'h0;
            y_q   <= y_q + (diff >>> 10) + ((diff != 26'sh0 && (diff >>> 10) == 26'sh0) ?
                     (diff[25] ? -26'sh1 : 26'sh1) : 26'sh0);
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule

// ==== rtl/srs_hold.v ====
// position hold loop used while zero clamp is engaged
`timescale 1ns/1ps
`include "srs_defs.vh"
module srs_hold (
    input  wire               clk,
    input  wire               reset,
    input  wire               engage,
    input  wire signed [31:0] pos_fb,
    output reg  signed [15:0] hold_speed
);
    reg                engage_q;
    reg  signed [31:0] hold_pos_q;
    wire signed [31:0] err   = hold_pos_q - pos_fb;
    wire signed [39:0] drive = err * $signed({1'b0, `SRS_HOLD_KP});

    always @(posedge clk) begin
        if (reset) begin
            engage_q   <= 1'b0;
            hold_pos_q <= 32'sh0;
            hold_speed <= 16'sh0;
        end else begin
            engage_q <= engage;
            if (engage && !engage_q)
                hold_pos_q <= pos_fb;
            if (!engage_q || (err >= -32'sh1 && err <= 32'sh1))
                hold_speed <= 16'sh0;
            else if (drive > 40'sh7fff)
                hold_speed <= 16'sh7fff;
            else if (drive < -40'sh7fff)
                hold_speed <= -16'sh7fff;
            else
                hold_speed <= drive[15:0];
        end
    end
endmodule

// ==== rtl/srs_top.v ====
// speed reference shaper: ahb-lite registers, scaling, offset, soft start, zero clamp
`timescale 1ns/1ps
`include "srs_defs.vh"
module srs_top #(
    parameter CYC_PER_MS = `SRS_MS_NS / `SRS_CLK_NS
) (
    input  wire               CORE_CLK,
    input  wire               RESET,
    input  wire               HSEL,
    input  wire [31:0]        HADDR,
    input  wire [1:0]         HTRANS,
    input  wire               HWRITE,
    input  wire [2:0]         HSIZE,
    input  wire [31:0]        HWDATA,
    input  wire               HREADY,
    output wire               HREADYOUT,
    output wire               HRESP,
    output reg  [31:0]        HRDATA,
    input  wire signed [15:0] VREF_MV,
    input  wire               SERVO_ON,
    input  wire [7:0]         DIN_N,
    input  wire signed [31:0] POS_FB,
    output reg  signed [15:0] SPEED_CMD,
    output reg                CLAMP_ACTIVE,
    output reg                SPEED_MODE
);
    localparam STEP_DIV = CYC_PER_MS / 1000;
    localparam AO_IDLE  = 1'b0;
    localparam AO_RUN   = 1'b1;

    // ****************************************
    // bus slave
    // ****************************************
    reg         wr_q;
    reg  [7:0]  wa_q;
    reg  [7:0]  mode_pend_q, mode_act_q, alloc_a_q, alloc_b_q;
    reg  [11:0] gain_q, thr_q;
    reg  [13:0] accel_q, decel_q, srise_q, filt_q;
    reg  signed [11:0] offset_q;
    reg         ao_state_q, ao_done_q;
    reg  [4:0]  ao_cnt_q;
    reg  signed [20:0] ao_sum_q;
    reg  [31:0] ms_cnt_q;
    reg  signed [15:0] ref_rpm_q, shaped;
    wire        take = HSEL && HREADY && HTRANS[1];
    wire        ms_tick = (ms_cnt_q == CYC_PER_MS - 1);
    wire        clamp_now;
    wire [3:0]  ctl_mode = mode_act_q[3:0];
    wire [1:0]  crv_mode = mode_act_q[5:4];
    wire [1:0]  shp_mode = mode_act_q[7:6];

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            wr_q   <= 1'b0;
            wa_q   <= 8'h00;
            HRDATA <= 32'h0;
        end else begin
            wr_q <= take && HWRITE;
            wa_q <= HADDR[7:0];
            if (take && !HWRITE) begin
                case ({HADDR[7:2], 2'b00})
                    `SRS_A_MODE:    HRDATA <= {24'h0, mode_pend_q};
                    `SRS_A_GAIN:    HRDATA <= {20'h0, gain_q};
                    `SRS_A_ACCEL:   HRDATA <= {18'h0, accel_q};
                    `SRS_A_DECEL:   HRDATA <= {18'h0, decel_q};
                    `SRS_A_SRISE:   HRDATA <= {18'h0, srise_q};
                    `SRS_A_FILT:    HRDATA <= {18'h0, filt_q};
                    `SRS_A_THR:     HRDATA <= {20'h0, thr_q};
                    `SRS_A_ALLOC_A: HRDATA <= {24'h0, alloc_a_q};
                    `SRS_A_ALLOC_B: HRDATA <= {24'h0, alloc_b_q};
                    `SRS_A_OFFSET:  HRDATA <= {{20{offset_q[11]}}, offset_q};
                    `SRS_A_STATUS:  HRDATA <= {12'h0, mode_act_q, 8'h0, ao_done_q,
                                               ao_state_q, CLAMP_ACTIVE, SPEED_MODE};
                    `SRS_A_SPEED:   HRDATA <= {{16{SPEED_CMD[15]}}, SPEED_CMD};
                    default:        HRDATA <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************
    // parameter registers
    // ****************************************
    wire ctrl_wr = wr_q && ({wa_q[7:2], 2'b00} == `SRS_A_CTRL);
    wire factory = ctrl_wr && HWDATA[`SRS_CTRL_FACTORY];
    wire wdata_signed_ok = ($signed(HWDATA) >= -32'sd1024) && ($signed(HWDATA) <= 32'sd1024);

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            mode_pend_q <= `SRS_RST_MODE;
            mode_act_q  <= `SRS_RST_MODE;
            gain_q      <= `SRS_RST_GAIN;
            accel_q     <= `SRS_RST_TIME;
            decel_q     <= `SRS_RST_TIME;
            srise_q     <= `SRS_RST_TIME;
            filt_q      <= `SRS_RST_TIME;
            thr_q       <= `SRS_RST_THR;
            alloc_a_q   <= `SRS_RST_ALLOC;
            alloc_b_q   <= `SRS_RST_ALLOC;
        end else if (factory) begin
            mode_pend_q <= `SRS_RST_MODE;
            gain_q      <= `SRS_RST_GAIN;
            accel_q     <= `SRS_RST_TIME;
            decel_q     <= `SRS_RST_TIME;
            srise_q     <= `SRS_RST_TIME;
            filt_q      <= `SRS_RST_TIME;
            thr_q       <= `SRS_RST_THR;
            alloc_a_q   <= `SRS_RST_ALLOC;
            alloc_b_q   <= `SRS_RST_ALLOC;
        end else if (ctrl_wr) begin
            if (HWDATA[`SRS_CTRL_RESTART])
                mode_act_q <= mode_pend_q;
        end else if (wr_q) begin
            case ({wa_q[7:2], 2'b00})
                `SRS_A_MODE:    mode_pend_q <= HWDATA[7:0];
                `SRS_A_GAIN:    if (HWDATA <= `SRS_MAX_GAIN) gain_q <= HWDATA[11:0];
                `SRS_A_ACCEL:   if (HWDATA <= `SRS_MAX_TIME) accel_q <= HWDATA[13:0];
                `SRS_A_DECEL:   if (HWDATA <= `SRS_MAX_TIME) decel_q <= HWDATA[13:0];
                `SRS_A_SRISE:   if (HWDATA <= `SRS_MAX_TIME) srise_q <= HWDATA[13:0];
                `SRS_A_FILT:    if (HWDATA <= `SRS_MAX_TIME) filt_q <= HWDATA[13:0];
                `SRS_A_THR:     if (HWDATA <= `SRS_MAX_THR) thr_q <= HWDATA[11:0];
                `SRS_A_ALLOC_A: alloc_a_q <= HWDATA[7:0];
                `SRS_A_ALLOC_B: alloc_b_q <= HWDATA[7:0];
                default:        mode_pend_q <= mode_pend_q;
            endcase
        end
    end

    // ****************************************
    // offset: auto measurement and manual entry
    // ****************************************
    always @(posedge CORE_CLK) begin
        if (RESET)
            ms_cnt_q <= 32'h0;
        else
            ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
    end

    // offset is deliberately outside the factory restore path
    // offset kept on restore
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            offset_q   <= 12'sh0;
            ao_state_q <= AO_IDLE;
            ao_done_q  <= 1'b0;
            ao_cnt_q   <= 5'h0;
            ao_sum_q   <= 21'sh0;
        end else begin
            case (ao_state_q)
                AO_IDLE: begin
                    if (ctrl_wr && HWDATA[`SRS_CTRL_AUTO_OFS] && !SERVO_ON) begin
                        ao_state_q <= AO_RUN;
                        ao_done_q  <= 1'b0;
                        ao_cnt_q   <= 5'h0;
                        ao_sum_q   <= 21'sh0;
                    end else if (wr_q && ({wa_q[7:2], 2'b00} == `SRS_A_OFFSET)
                                 && wdata_signed_ok) begin
                        offset_q <= HWDATA[11:0];
                    end
                end
                AO_RUN: begin
                    // servo switched on mid-measurement spoils it: abandon
                    if (SERVO_ON) begin
                        ao_state_q <= AO_IDLE;
                    end else if (ao_cnt_q == `SRS_AO_SAMPLES) begin
                        ao_state_q <= AO_IDLE;
                        ao_done_q  <= 1'b1;
                        if ((ao_sum_q >>> `SRS_AO_SHIFT) > 21'sd1024)
                            offset_q <= `SRS_OFS_LIMIT;
                        else if ((ao_sum_q >>> `SRS_AO_SHIFT) < -21'sd1024)
                            offset_q <= -`SRS_OFS_LIMIT;
                        else
                            offset_q <= ao_sum_q[15:4];
                    end else if (ms_tick) begin
                        ao_sum_q <= ao_sum_q + {{5{VREF_MV[15]}}, VREF_MV};
                        ao_cnt_q <= ao_cnt_q + 5'h1;
                    end
                end
                default: ao_state_q <= AO_IDLE;
            endcase
        end
    end

    // ****************************************
    // scaling: rpm = (mV - offset) * gain / 1000
    // ****************************************
    wire signed [16:0] vdiff = {VREF_MV[15], VREF_MV} - {{5{offset_q[11]}}, offset_q};
    wire signed [29:0] vprod = vdiff * $signed({1'b0, gain_q});
    // exact divide toward zero: 1 V at gain 150 must give 150 rpm, not 149
    wire signed [30:0] rpm   = vprod / 30'sd1000;

    always @(posedge CORE_CLK) begin
        if (RESET)
            ref_rpm_q <= 16'sh0;
        else if (rpm > 31'sh7fff)
            ref_rpm_q <= 16'sh7fff;
        else if (rpm < -31'sh7fff)
            ref_rpm_q <= -16'sh7fff;
        else
            ref_rpm_q <= rpm[15:0];
    end

    // ****************************************
    // ramp profile
    // ****************************************
    reg  signed [15:0] ramp_q;
    reg         [31:0] ramp_cnt_q;
    wire        away  = (ramp_q >= 16'sh0 && ref_rpm_q > ramp_q) ||
                        (ramp_q <= 16'sh0 && ref_rpm_q < ramp_q);
    wire [13:0] rtime = away ? accel_q : decel_q;
    wire [31:0] rstep = rtime * STEP_DIV;

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            ramp_q     <= 16'sh0;
            ramp_cnt_q <= 32'h0;
        end else if (rtime == 14'h0 || crv_mode != `SRS_CRV_RAMP) begin
            ramp_q     <= ref_rpm_q;
            ramp_cnt_q <= 32'h0;
        end else if (ramp_q == ref_rpm_q) begin
            ramp_cnt_q <= 32'h0;
        end else if (ramp_cnt_q >= rstep - 32'h1) begin
            ramp_cnt_q <= 32'h0;
            ramp_q     <= (ref_rpm_q > ramp_q) ? ramp_q + 16'sh1 : ramp_q - 16'sh1;
        end else begin
            ramp_cnt_q <= ramp_cnt_q + 32'h1;
        end
    end

    // ****************************************
    // s-curve profile
    // ****************************************
    reg  signed [15:0] s_out_q, s_start_q, s_tgt_q;
    reg  signed [16:0] s_delta_q;
    reg         [10:0] s_prog_q;
    reg         [31:0] s_cnt_q;
    reg         [10:0] s_f;
    wire        [39:0] s_prod  = srise_q * CYC_PER_MS;
    wire        [31:0] s_intvl = (s_prod[39:10] == 30'h0) ? 32'h1 : {2'h0, s_prod[39:10]};
    wire        [21:0] p2      = s_prog_q * s_prog_q;
    wire        [33:0] p3      = p2 * (12'd3072 - {s_prog_q, 1'b0});
    wire        [10:0] smooth  = p3[30:20];
    wire signed [28:0] s_mul   = s_delta_q * $signed({1'b0, s_f});
    // sums kept wide so the blends do not lose their carry near full progress
    wire        [12:0] s_sum1  = {2'b00, smooth} + {2'b00, s_prog_q};
    wire        [12:0] s_sum3  = {1'b0, smooth, 1'b0} + {2'b00, smooth} + {2'b00, s_prog_q};

    // transition shape blends smoothstep and linear
    always @* begin
        case (shp_mode)
            2'h0:    s_f = smooth;
            2'h1:    s_f = s_sum1[11:1];
            2'h2:    s_f = s_sum3[12:2];
            default: s_f = s_prog_q;
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            s_out_q   <= 16'sh0;
            s_start_q <= 16'sh0;
            s_tgt_q   <= 16'sh0;
            s_delta_q <= 17'sh0;
            s_prog_q  <= 11'h0;
            s_cnt_q   <= 32'h0;
        end else if (srise_q == 14'h0) begin
            // keep the curve anchored so a later nonzero rise time does not jump
            s_out_q   <= ref_rpm_q;
            s_start_q <= ref_rpm_q;
            s_delta_q <= 17'sh0;
            s_tgt_q   <= ref_rpm_q;
            s_prog_q <= `SRS_SCURVE_FULL;
        end else if (ref_rpm_q != s_tgt_q) begin
            s_start_q <= s_out_q;
            s_delta_q <= ref_rpm_q - s_out_q;
            s_tgt_q   <= ref_rpm_q;
            s_prog_q  <= 11'h0;
            s_cnt_q   <= 32'h0;
        end else begin
            s_out_q <= s_start_q + s_mul[25:10];
            if (s_prog_q != `SRS_SCURVE_FULL) begin
                if (s_cnt_q >= s_intvl - 32'h1) begin
                    s_cnt_q  <= 32'h0;
                    s_prog_q <= s_prog_q + 11'h1;
                end else begin
                    s_cnt_q <= s_cnt_q + 32'h1;
                end
            end
        end
    end

    // ****************************************
    // filter profiles
    // ****************************************
    wire signed [15:0] filt_io [0:2];
    assign filt_io[0] = ref_rpm_q;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lpf
            srs_lpf #(.CYC_PER_MS(CYC_PER_MS)) u_lpf (
                .clk    (CORE_CLK),
                .reset  (RESET),
                .tau_ms (filt_q),
                .din    (filt_io[g]),
                .dout   (filt_io[g+1])
            );
        end
    endgenerate

    always @* begin
        case (crv_mode)
            `SRS_CRV_RAMP:   shaped = ramp_q;
            `SRS_CRV_SCURVE: shaped = s_out_q;
            `SRS_CRV_FILT1:  shaped = filt_io[1];
            default:         shaped = filt_io[2];
        endcase
    end

    // ****************************************
    // zero clamp
    // ****************************************
    wire        zc_a   = (alloc_a_q[3:0] < `SRS_PIN_NONE_MIN) && !DIN_N[alloc_a_q[2:0]];
    wire        zc_b   = (alloc_b_q[3:0] < `SRS_PIN_NONE_MIN) && !DIN_N[alloc_b_q[2:0]];
    wire        pcon   = (alloc_a_q[7:4] < `SRS_PIN_NONE_MIN) && !DIN_N[alloc_a_q[6:4]];
    wire [15:0] ref_abs = ref_rpm_q[15] ? -ref_rpm_q : ref_rpm_q;
    wire        below  = ref_abs < {4'h0, thr_q};
    wire        is_spd = (ctl_mode == `SRS_CTL_ANALOG) || (ctl_mode == `SRS_CTL_ZERO_CLAMP_INPUT);
    wire signed [15:0] hold_speed;

    assign clamp_now = below && (((ctl_mode == `SRS_CTL_ANALOG) && (zc_a || zc_b)) ||
                                 ((ctl_mode == `SRS_CTL_ZERO_CLAMP_INPUT) && pcon));

    srs_hold u_hold (
        .clk        (CORE_CLK),
        .reset      (RESET),
        .engage     (clamp_now),
        .pos_fb     (POS_FB),
        .hold_speed (hold_speed)
    );

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            SPEED_CMD    <= 16'sh0;
            CLAMP_ACTIVE <= 1'b0;
            SPEED_MODE   <= 1'b1;
        end else begin
            // only speed modes drive the output
            SPEED_MODE   <= is_spd;
            CLAMP_ACTIVE <= clamp_now;
            SPEED_CMD    <= !is_spd ? 16'sh0 : (clamp_now ? hold_speed : shaped);
        end
    end
endmodule

// ==== rtl/srs_lpf_fix_note.v ====
// (intentionally empty)

// ==== verif/srs_top_props.sv ====
// port-level checks for the speed reference shaper
`timescale 1ns/1ps
module srs_props (
    input wire               CORE_CLK,
    input wire               RESET,
    input wire               HSEL,
    input wire [31:0]        HADDR,
    input wire [1:0]         HTRANS,
    input wire               HWRITE,
    input wire               HREADY,
    input wire               HREADYOUT,
    input wire               HRESP,
    input wire [7:0]         DIN_N,
    input wire signed [31:0] POS_FB,
    input wire signed [15:0] SPEED_CMD,
    input wire               CLAMP_ACTIVE,
    input wire               SPEED_MODE
);
    reg       ctl_q;
    reg [3:0] since_q;
    // any control write counts as a possible restart
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            ctl_q   <= 1'b0;
            since_q <= 4'h0;
        end else begin
            ctl_q   <= HSEL & HREADY & HTRANS[1] & HWRITE & (HADDR[7:2] == 6'h0);
            since_q <= ctl_q ? 4'h0 : (since_q == 4'hf ? since_q : since_q + 4'h1);
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    a_reset_out: assert property ($fell(RESET) |-> SPEED_CMD == 16'sh0 && SPEED_MODE)
        else $error("outputs wrong after reset");
    a_mode_restart: assert property ($changed(SPEED_MODE) |-> since_q < 4'h4)
        else $error("mode changed without restart");
    a_clamp_mode: assert property (CLAMP_ACTIVE |-> SPEED_MODE)
        else $error("clamp outside speed mode");
    a_clamp_pin: assert property ((DIN_N == 8'hff) [*3] |-> !CLAMP_ACTIVE)
        else $error("clamp with all inputs high");
    a_other_zero: assert property ((!SPEED_MODE) [*3] |-> SPEED_CMD == 16'sh0)
        else $error("speed nonzero in other mode");
    a_hold_ignore: assert property ((CLAMP_ACTIVE && $stable(POS_FB)) [*3] |-> $stable(SPEED_CMD))
        else $error("clamped speed follows reference");
    a_hold_zero: assert property ($rose(CLAMP_ACTIVE) ##0 (CLAMP_ACTIVE && $stable(POS_FB)) [*4]
        |-> SPEED_CMD == 16'sh0)
        else $error("hold speed nonzero at latched spot");
endmodule

// ==== verif/srs_host.sv ====
// host controller model: reference, servo-on, discrete pins, encoder
`timescale 1ns/1ps
module srs_host (
    input  wire               clk,
    output reg signed [15:0]  vref_mv,
    output reg                servo_on,
    output reg  [7:0]         din_n,
    output reg signed [31:0]  pos_fb
);
    initial begin
        vref_mv  = 16'sh0;
        servo_on = 1'b0;
        din_n    = 8'hff;
        pos_fb   = 32'sh0;
    end
    task automatic drive(input logic signed [15:0] v, input logic s, input logic [7:0] p,
                         input logic signed [31:0] e);
        @(posedge clk);
        vref_mv  <= v;
        servo_on <= s;
        din_n    <= p;
        pos_fb   <= e;
    endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the speed reference shaper
`timescale 1ns/1ps
`include "srs_defs.vh"
`define CHK(n, e, s) begin \
    total_checks++; \
    if ((s) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED %s exp %h got %h", n, e, s); \
    end \
end
module tb;
    logic              clk, rst, hwrite;
    logic [1:0]        htrans;
    logic [31:0]       haddr, hwdata, d;
    wire  [31:0]       hrdata;
    wire               hrdy, hresp, clamp, smode, son;
    wire  [7:0]        din_n;
    wire signed [15:0] vref, spd;
    wire signed [31:0] pos;
    int                err_total, total_checks, cyc;
    srs_top #(.CYC_PER_MS(1000)) i_dut (.CORE_CLK(clk), .RESET(rst), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .VREF_MV(vref),
        .SERVO_ON(son), .DIN_N(din_n), .POS_FB(pos), .SPEED_CMD(spd),
        .CLAMP_ACTIVE(clamp), .SPEED_MODE(smode));
    srs_host i_host (.clk(clk), .vref_mv(vref), .servo_on(son), .din_n(din_n), .pos_fb(pos));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            finish_test();
        end
    end
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("register", e, d)
    endtask
    task automatic ref_in(input logic signed [15:0] v, input logic [7:0] p, input int e);
        i_host.drive(v, 1'b1, p, e);
        repeat (6) @(posedge clk);
        #1;
    endtask
    function automatic logic [31:0] rpm(input int v, input int o, input int g);
        longint p;
        p = longint'(v - o) * g / 1000;
        return 32'(p);
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        int vs[3] = '{1000, 5000, -10000};
        rd(`SRS_A_GAIN, 32'h96);
        rd(`SRS_A_THR, 32'ha);
        rd(`SRS_A_ALLOC_A, 32'hff);
        rd(8'h3c, 32'h0);
        wr(`SRS_A_GAIN, 32'hbb9);
        rd(`SRS_A_GAIN, 32'h96);
        wr(`SRS_A_GAIN, 32'hbb8);
        rd(`SRS_A_GAIN, 32'hbb8);
        wr(`SRS_A_GAIN, 32'h96);
        foreach (vs[i]) begin
            ref_in(vs[i], 8'hff, 0);
            rd(`SRS_A_SPEED, rpm(vs[i], 0, 150));
        end
    endtask
    task t_offset;
        ref_in(0, 8'hff, 0);
        wr(`SRS_A_OFFSET, 32'h401);
        rd(`SRS_A_OFFSET, 32'h0);
        wr(`SRS_A_OFFSET, 32'hfffffc00);
        rd(`SRS_A_OFFSET, 32'hfffffc00);
        rd(`SRS_A_SPEED, rpm(0, -1024, 150));
        wr(`SRS_A_GAIN, 32'h3e8);
        wr(`SRS_A_CTRL, 32'h2);
        rd(`SRS_A_GAIN, 32'h96);
        rd(`SRS_A_OFFSET, 32'hfffffc00);
    endtask
    task t_auto;
        i_host.drive(16'sd37, 1'b0, 8'hff, 0);
        wr(`SRS_A_CTRL, 32'h4);
        d = 32'h0;
        for (int i = 0; i < 40 && d[3] !== 1'b1; i++) begin
            repeat (500) @(posedge clk);
            bus(1'b0, `SRS_A_STATUS, 32'h0);
        end
        `CHK("auto done", 1'b1, d[3])
        rd(`SRS_A_OFFSET, 32'd37);
        rd(`SRS_A_SPEED, 32'h0);
        wr(`SRS_A_OFFSET, 32'h0);
    endtask
    task t_ramp;
        wr(`SRS_A_ACCEL, 32'd20);
        wr(`SRS_A_DECEL, 32'd10);
        ref_in(1000, 8'hff, 0);
        repeat (1500) @(posedge clk);
        `CHK("accel mid", 1'b1, spd >= 70 && spd <= 80)
        repeat (1700) @(posedge clk);
        `CHK("accel end", 16'sd150, spd)
        ref_in(0, 8'hff, 0);
        repeat (750) @(posedge clk);
        `CHK("decel mid", 1'b1, spd >= 68 && spd <= 80)
        repeat (900) @(posedge clk);
        `CHK("decel end", 16'sd0, spd)
        wr(`SRS_A_ACCEL, 32'd10001);
        rd(`SRS_A_ACCEL, 32'd20);
        wr(`SRS_A_ACCEL, 32'h0);
        wr(`SRS_A_DECEL, 32'h0);
    endtask
    task t_clamp;
        ref_in(40, 8'hf7, 0);
        `CHK("clamp unassigned", 1'b0, clamp)
        wr(`SRS_A_ALLOC_A, 32'hf3);
        repeat (4) @(posedge clk);
        `CHK("clamp on", 1'b1, clamp)
        ref_in(40, 8'hf7, 5);
        `CHK("hold push", 16'hffec, spd)
        ref_in(40, 8'hf7, 1);
        `CHK("hold within", 16'h0, spd)
        ref_in(1000, 8'hf7, 0);
        `CHK("above level", 1'b0, clamp)
        ref_in(40, 8'hff, 0);
        `CHK("input high", 1'b0, clamp)
        wr(`SRS_A_THR, 32'hbb9);
        rd(`SRS_A_THR, 32'ha);
    endtask
    task t_curves;
        wr(`SRS_A_MODE, 32'h20);
        wr(`SRS_A_CTRL, 32'h1);
        ref_in(1000, 8'hff, 0);
        `CHK("filter one", 16'sd150, spd)
        wr(`SRS_A_MODE, 32'h30);
        wr(`SRS_A_CTRL, 32'h1);
        ref_in(-1000, 8'hff, 0);
        `CHK("filter two", -16'sd150, spd)
        wr(`SRS_A_SRISE, 32'd10);
        wr(`SRS_A_MODE, 32'h10);
        wr(`SRS_A_CTRL, 32'h1);
        ref_in(0, 8'hff, 0);
        repeat (5000) @(posedge clk);
        `CHK("s-curve mid", 1'b1, spd >= -84 && spd <= -66)
        repeat (6000) @(posedge clk);
        `CHK("s-curve end", 16'sd0, spd)
        wr(`SRS_A_SRISE, 32'h0);
    endtask
    task t_modes;
        wr(`SRS_A_MODE, 32'h1);
        `CHK("no restart", 1'b1, smode)
        wr(`SRS_A_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        `CHK("mode one", 1'b0, smode)
        wr(`SRS_A_MODE, 32'ha);
        wr(`SRS_A_ALLOC_A, 32'h2f);
        wr(`SRS_A_CTRL, 32'h1);
        ref_in(40, 8'hfb, 0);
        `CHK("prop clamp", 1'b1, clamp)
        ref_in(40, 8'hff, 0);
        `CHK("prop high", 1'b0, clamp)
    endtask
    initial begin
        rst    = 1'b1;
        htrans = 2'h0;
        haddr  = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_offset;
        t_auto;
        t_ramp;
        t_clamp;
        t_curves;
        t_modes;
        finish_test;
    end
endmodule
bind srs_top srs_props i_props (.CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DIN_N(DIN_N), .POS_FB(POS_FB),
    .SPEED_CMD(SPEED_CMD), .CLAMP_ACTIVE(CLAMP_ACTIVE), .SPEED_MODE(SPEED_MODE));
